/* File: logic/eer_pkg.sv */
/*
 * eer_pkg: constants shared by the ecc error reporting block.
 * assumes the ecc decoder and command logic live outside and talk to this block
 * through plain event and command ports.
 */
package eer_pkg;
    // ==========================================================
    // status word layout
    localparam int          STAT_W          = 16;
    localparam int          BIT_UNIT_OFF    = 0;
    localparam int          BIT_UNIT_DATA   = 1;
    localparam int          BIT_CHECK_CODE  = 2;
    localparam int          BIT_CORR_SEEN   = 3;
    localparam int          BIT_DOUBLE_SEEN = 4;
    localparam logic [15:0] STAT_RESET      = 16'h0000;
    localparam logic [15:0] CNT_RESET       = 16'h0000;
    localparam logic [15:0] CNT_MAX         = 16'hFFFF;
    // ==========================================================
    // address capture layout
    localparam int          ADDR_W          = 25;
    localparam int          LOW_LSB         = 3;
    localparam int          LOW_MSB         = 15;
    localparam int          HIGH_LSB        = 16;
    localparam logic [15:0] ADDR_RESET      = 16'h0000;
    // ==========================================================
    // density and register selector codes
    typedef enum logic [1:0] {
        EER_DENS_128 = 2'h0,
        EER_DENS_256 = 2'h1,
        EER_DENS_512 = 2'h2
    } eer_density_e;
    typedef enum logic [1:0] {
        EER_SEL_STATUS = 2'h0,
        EER_SEL_ADDR_L = 2'h1,
        EER_SEL_ADDR_H = 2'h2,
        EER_SEL_COUNT  = 2'h3
    } eer_sel_e;
    // ==========================================================
    // link stall timing
    localparam int          HOST_TIMEOUT_CK = 32;
endpackage

/* File: logic/eer_sync.sv */
/*
 * eer_sync: two flip-flop level synchroniser.
 * assumes the input is a slowly changing level from another clock domain.
 */
`timescale 1ns/1ns
module eer_sync
    import eer_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_q;
    // ==========================================================
    // first stage is read only by the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

/* File: logic/eer_stall.sv */
/*
 * eer_stall: link side read strobe stall, clocked by the link clock.
 * assumes chip select low marks a transaction and the normal strobe comes in.
 */
`timescale 1ns/1ns
module eer_stall
    import eer_pkg::*;
(
    input  wire logic link_clk_i,
    input  wire logic rst_n_i,
    input  wire logic cs_n_i,
    input  wire logic stall_req_i,
    input  wire logic strobe_i,
    output logic      strobe_o,
    output logic      stalled_o
);
    logic stall_q;
    // ==========================================================
    // stall latches on a double error and ends only with chip select high
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stall_q <= 1'b0;
        end else if (cs_n_i) begin
            stall_q <= 1'b0;
        end else if (stall_req_i) begin
            stall_q <= 1'b1;
        end
    end
    // cs high also releases combinationally, since the clock may stop then
    assign stalled_o = stall_q & ~cs_n_i;
    assign strobe_o  = stalled_o ? 1'b0 : strobe_i;
endmodule

/* File: logic/eer_top.sv */
/*
 * eer_top: ecc error reporting - status word, first error address capture,
 * saturating error counter and read strobe stall on double errors.
 * assumes: the ecc decoder reports one event per half-page read on sys_clk_i;
 * the command logic decodes overlay entry/exit, unit select and counter clear;
 * chip select and the strobe path run on link_clk_i.
 */
`timescale 1ns/1ns
module eer_top
    import eer_pkg::*;
#(
    parameter eer_density_e DENSITY = EER_DENS_256
)
(
    input  wire logic                sys_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                link_clk_i,
    input  wire logic                cs_n_i,
    input  wire logic                strobe_i,
    output logic                     strobe_o,
    input  wire logic                hp_event_i,
    input  wire logic [ADDR_W-1:0]   hp_addr_i,
    input  wire logic                hp_single_i,
    input  wire logic                hp_check_i,
    input  wire logic                hp_double_i,
    input  wire logic                hp_multi_prog_i,
    input  wire logic                overlay_mode_i,
    input  wire logic                any_overlay_i,
    input  wire logic                overlay_exit_i,
    input  wire logic                unit_sel_i,
    input  wire logic [ADDR_W-1:0]   unit_addr_i,
    input  wire logic                unit_ecc_off_i,
    input  wire logic                unit_data_err_i,
    input  wire logic                unit_check_err_i,
    input  wire logic                count_clear_i,
    input  wire logic                trap_type_select_i,
    input  wire logic                strobe_stall_control_i,
    input  wire eer_sel_e            rd_sel_i,
    output logic [STAT_W-1:0]        rd_data_o,
    output logic                     addr_valid_o
);
    // ==========================================================
    // state
    logic              corr_seen_q, corr_seen_d;
    logic              dbl_seen_q, dbl_seen_d;
    logic [2:0]        unit_bits_q, unit_bits_d;
    logic              trapped_q, trapped_d;
    logic [ADDR_W-1:0] trap_addr_q, trap_addr_d;
    logic [15:0]       count_q, count_d;
    logic [ADDR_W-5:0] last_hp_q;
    logic              last_hp_vld_q;
    logic              cs_sys;
    logic              stall_tgl_q;
    logic              stall_tgl_link;
    logic              stall_tgl_link_q;
    logic              stall_pulse_link;
    logic [STAT_W-1:0] rd_data_d;

    // ==========================================================
    // event qualification
    wire ecc_live     = hp_event_i & ~(hp_multi_prog_i & ~trap_type_select_i);
    wire any_err      = hp_single_i | hp_check_i | hp_double_i;
    wire single_err   = hp_single_i | hp_check_i;
    wire big_part     = (DENSITY == EER_DENS_512);
    // largest part traps doubles only, others per select bit
    wire trap_type_ok = hp_double_i | (single_err & ~big_part & trap_type_select_i);
    wire do_trap      = ecc_live & trap_type_ok & ~trapped_q;
    wire [ADDR_W-5:0] hp_index = hp_addr_i[ADDR_W-1:4];
    wire same_hp      = last_hp_vld_q & (last_hp_q == hp_index) & ~cs_sys;
    wire do_count     = ecc_live & any_err & ~big_part & ~any_overlay_i & ~same_hp;
    wire stall_event  = ecc_live & hp_double_i & ~strobe_stall_control_i;

    // ==========================================================
    // status word next state; exit clears, new events set in the same cycle
    always_comb begin
        corr_seen_d = overlay_exit_i ? 1'b0 : corr_seen_q;
        dbl_seen_d  = overlay_exit_i ? 1'b0 : dbl_seen_q;
        unit_bits_d = overlay_exit_i ? 3'h0 : unit_bits_q;
        if (ecc_live && single_err) begin
            corr_seen_d = 1'b1;
        end
        if (ecc_live && hp_double_i) begin
            dbl_seen_d = 1'b1;
        end
        if (unit_sel_i) begin
            unit_bits_d = {unit_check_err_i, unit_data_err_i, unit_ecc_off_i};
        end
    end

    // ==========================================================
    // address capture next state
    always_comb begin
        trapped_d   = overlay_exit_i ? 1'b0 : trapped_q;
        trap_addr_d = overlay_exit_i ? '0 : trap_addr_q;
        if (do_trap) begin
            trapped_d   = 1'b1;
            trap_addr_d = {hp_addr_i[ADDR_W-1:LOW_LSB], 3'h0};
        end
    end

    // ==========================================================
    // counter next state: clear command wins in overlay mode, otherwise saturating add
    always_comb begin
        count_d = count_q;
        if (count_clear_i && overlay_mode_i) begin
            count_d = CNT_RESET;
        end else if (do_count && count_q != CNT_MAX) begin
            count_d = count_q + 16'h0001;
        end
    end

    // ==========================================================
    // register updates
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            corr_seen_q <= 1'b0;
            dbl_seen_q  <= 1'b0;
            unit_bits_q <= 3'h0;
            trapped_q   <= 1'b0;
            trap_addr_q <= '0;
            count_q     <= CNT_RESET;
        end else begin
            corr_seen_q <= corr_seen_d;
            dbl_seen_q  <= dbl_seen_d;
            unit_bits_q <= unit_bits_d;
            trapped_q   <= trapped_d;
            trap_addr_q <= trap_addr_d;
            count_q     <= count_d;
        end
    end

    // ==========================================================
    // per-burst half-page memory; a new transaction counts again
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_hp_q     <= '0;
            last_hp_vld_q <= 1'b0;
        end else if (cs_sys) begin
            last_hp_vld_q <= 1'b0;
        end else if (do_count) begin
            last_hp_q     <= hp_index;
            last_hp_vld_q <= 1'b1;
        end
    end

    // ==========================================================
    // read mux; reserved bits read zero, upper address masked by density
    wire [STAT_W-1:0] status_word = {11'h000, dbl_seen_q, corr_seen_q, unit_bits_q};
    wire [8:0] hi_mask = big_part ? 9'h1FF : (DENSITY == EER_DENS_256) ? 9'h0FF : 9'h07F;
    wire [15:0] addr_low  = {trap_addr_q[LOW_MSB:LOW_LSB], 3'h0};
    wire [15:0] addr_high = {7'h00, trap_addr_q[ADDR_W-1:HIGH_LSB] & hi_mask};
    always_comb begin
        case (rd_sel_i)
            EER_SEL_STATUS: rd_data_d = status_word;
            EER_SEL_ADDR_L: rd_data_d = addr_low;
            EER_SEL_ADDR_H: rd_data_d = addr_high;
            EER_SEL_COUNT:  rd_data_d = count_q;
            default:        rd_data_d = STAT_RESET;
        endcase
    end
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o    <= STAT_RESET;
            addr_valid_o <= 1'b0;
        end else begin
            rd_data_o    <= rd_data_d;
            addr_valid_o <= corr_seen_d | dbl_seen_d;
        end
    end

    // ==========================================================
    // stall request crosses to the link clock as a toggle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stall_tgl_q <= 1'b0;
        end else if (stall_event) begin
            stall_tgl_q <= ~stall_tgl_q;
        end
    end
    eer_sync u_cs_sync (
        .clk_i   (sys_clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (cs_n_i),
        .q_o     (cs_sys)
    );
    eer_sync u_stall_sync (
        .clk_i   (link_clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (stall_tgl_q),
        .q_o     (stall_tgl_link)
    );
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stall_tgl_link_q <= 1'b0;
        end else begin
            stall_tgl_link_q <= stall_tgl_link;
        end
    end
    assign stall_pulse_link = stall_tgl_link ^ stall_tgl_link_q;
    eer_stall u_stall (
        .link_clk_i  (link_clk_i),
        .rst_n_i     (rst_n_i),
        .cs_n_i      (cs_n_i),
        .stall_req_i (stall_pulse_link),
        .strobe_i    (strobe_i),
        .strobe_o    (strobe_o),
        .stalled_o   ()
    );

    // ==========================================================
    // checks
    property p_exit_clears;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        overlay_exit_i && !hp_event_i |=> !dbl_seen_q && !corr_seen_q && !trapped_q;
    endproperty
    a_exit_clears: assert property (p_exit_clears) else $error("exit left status set");
    property p_dbl_sets;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ecc_live && hp_double_i |=> dbl_seen_q;
    endproperty
    a_dbl_sets: assert property (p_dbl_sets) else $error("double not recorded");
    property p_corr_sets;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ecc_live && hp_single_i |=> corr_seen_q;
    endproperty
    a_corr_sets: assert property (p_corr_sets) else $error("correction not recorded");
    property p_sat;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        count_q == CNT_MAX && !count_clear_i |=> count_q == CNT_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("counter wrapped");
    property p_no_count_overlay;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        any_overlay_i && !count_clear_i |=> $stable(count_q);
    endproperty
    a_no_count_overlay: assert property (p_no_count_overlay) else $error("count in overlay");
    property p_trap_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        trapped_q && !overlay_exit_i |=> $stable(trap_addr_q);
    endproperty
    a_trap_hold: assert property (p_trap_hold) else $error("capture overwritten");
    property p_low_zero;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_sel_i == EER_SEL_ADDR_L |=> rd_data_o[2:0] == 3'h0;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low address bits set");
    property p_rsvd;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_sel_i == EER_SEL_STATUS |=> rd_data_o[15:5] == 11'h000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    // a stall request inside a frame, with the frame still open one link clock on
    sequence s_stall_armed;
        stall_pulse_link && !cs_n_i && !strobe_stall_control_i ##1 !cs_n_i;
    endsequence
    property p_strobe_low;
        @(posedge link_clk_i) disable iff (!rst_n_i)
        s_stall_armed |-> !strobe_o;
    endproperty
    a_strobe_low: assert property (p_strobe_low) else $error("strobe not stalled");
    property p_stall_release;
        @(posedge link_clk_i) disable iff (!rst_n_i)
        cs_n_i |-> strobe_o == strobe_i;
    endproperty
    a_stall_release: assert property (p_stall_release) else $error("strobe held after frame");
    // ==========================================================
    // counter, capture and unit status checks on the system clock
    property p_clear_count;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        count_clear_i && overlay_mode_i |=> count_q == CNT_RESET;
    endproperty
    a_clear_count: assert property (p_clear_count) else $error("counter not cleared");
    property p_clear_refused;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        count_clear_i && !overlay_mode_i && !do_count |=> $stable(count_q);
    endproperty
    a_clear_refused: assert property (p_clear_refused) else $error("clear outside overlay");
    property p_multi_off;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        hp_event_i && hp_multi_prog_i && !trap_type_select_i && !count_clear_i && !overlay_exit_i
            |=> $stable(count_q) && $stable(trap_addr_q);
    endproperty
    a_multi_off: assert property (p_multi_off) else $error("disabled unit reported");
    property p_big_no_count;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        big_part && !count_clear_i |=> $stable(count_q);
    endproperty
    a_big_no_count: assert property (p_big_no_count) else $error("largest part counted");
    property p_trap_valid;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        trapped_q |-> corr_seen_q || dbl_seen_q;
    endproperty
    a_trap_valid: assert property (p_trap_valid) else $error("capture without status");
    property p_trap_aligned;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        do_trap |=> trapped_q && trap_addr_q[2:0] == 3'h0;
    endproperty
    a_trap_aligned: assert property (p_trap_aligned) else $error("capture misaligned");
    property p_unit_off;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        unit_sel_i |=> unit_bits_q[0] == $past(unit_ecc_off_i);
    endproperty
    a_unit_off: assert property (p_unit_off) else $error("unit off bit wrong");
    property p_unit_err;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        unit_sel_i |=> unit_bits_q[2:1] == {$past(unit_check_err_i), $past(unit_data_err_i)};
    endproperty
    a_unit_err: assert property (p_unit_err) else $error("unit error bits wrong");
    property p_status_unit;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_sel_i == EER_SEL_STATUS |=> rd_data_o[2:0] == $past(unit_bits_q);
    endproperty
    a_status_unit: assert property (p_status_unit) else $error("unit status not shown");
    property p_count_step;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        do_count && count_q != CNT_MAX && !count_clear_i |=> count_q == $past(count_q) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter missed a step");
    property p_exit_unit;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        overlay_exit_i && !unit_sel_i |=> unit_bits_q == 3'h0;
    endproperty
    a_exit_unit: assert property (p_exit_unit) else $error("exit left unit bits");
endmodule

/* File: dv/eer_host_model.sv */
/*
 * eer_host_model: host controller on the link. frames chip select, makes the
 * link clock (30 ns, only inside frames plus two trailing edges) and flags a
 * bus error when the returned strobe stalls.
 * assumes frame_i comes from the bench and strobe_i is the strobe pin.
 */
`timescale 1ns/1ns
module eer_host_model (
    input  wire logic frame_i,
    input  wire logic strobe_i,
    output logic      link_clk_o,
    output logic      cs_n_o,
    output logic      bus_err_o
);
    int unsigned idle_cnt = 0;
    logic        last_q   = 1'b0;
    logic        err_q    = 1'b0;
    assign bus_err_o = err_q;
    // ==========================================================
    // framing: trailing edges let the stall logic see chip select high
    initial begin
        link_clk_o = 1'b0;
        cs_n_o = 1'b1;
        forever begin
            wait (frame_i);
            cs_n_o = 1'b0;
            while (frame_i) begin
                #15 link_clk_o = 1'b1;
                #15 link_clk_o = 1'b0;
            end
            cs_n_o = 1'b1;
            repeat (2) begin
                #15 link_clk_o = 1'b1;
                #15 link_clk_o = 1'b0;
            end
        end
    end
    // ==========================================================
    // stall watch: a strobe with no edge for more than 32 clocks is an error
    always @(posedge link_clk_o) begin
        last_q <= strobe_i;
        if (cs_n_o || strobe_i !== last_q) begin
            idle_cnt <= 0;
        end else begin
            idle_cnt <= idle_cnt + 1;
        end
        err_q <= !cs_n_o && idle_cnt > 32;
    end
endmodule

/* File: dv/eer_tb.sv */
/*
 * testbench: self-checking bench for eer_top, host model on the link side.
 * assumes eer_pkg, the design files and the host model are compiled first.
 */
`timescale 1ns/1ns
`define CK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
    import eer_pkg::*;
    // ==========================================================
    // signals
    logic              sys_clk_i, rst_n_i, hp_event_i, hp_single_i, hp_check_i;
    logic              strobe_i = 1'b0;
    logic              hp_double_i, hp_multi_prog_i, overlay_mode_i, any_overlay_i;
    logic              overlay_exit_i, unit_sel_i, unit_ecc_off_i, unit_data_err_i;
    logic              unit_check_err_i, count_clear_i, trap_type_select_i, frame;
    logic              strobe_stall_control_i, link_clk_i, cs_n_i, strobe_o, addr_valid_o;
    logic              bus_err;
    logic [ADDR_W-1:0] hp_addr_i, unit_addr_i;
    logic [15:0]       rd_data_o, rd_data_big;
    eer_sel_e          rd_sel_i;
    int                bad_count, cmp_count;
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // device core strobe toggles only while a frame is open
    always @(posedge link_clk_i) strobe_i <= !cs_n_i && !strobe_i;
    eer_top #(.DENSITY(EER_DENS_256)) u_dut (
        .sys_clk_i, .rst_n_i, .link_clk_i, .cs_n_i, .strobe_i, .strobe_o, .hp_event_i,
        .hp_addr_i, .hp_single_i, .hp_check_i, .hp_double_i, .hp_multi_prog_i,
        .overlay_mode_i, .any_overlay_i, .overlay_exit_i, .unit_sel_i, .unit_addr_i,
        .unit_ecc_off_i, .unit_data_err_i, .unit_check_err_i, .count_clear_i,
        .trap_type_select_i, .strobe_stall_control_i, .rd_sel_i, .rd_data_o, .addr_valid_o
    );
    eer_host_model u_host (.frame_i(frame), .strobe_i(strobe_o), .link_clk_o(link_clk_i),
                           .cs_n_o(cs_n_i), .bus_err_o(bus_err));
    // largest density copy: doubles only are trapped, nothing counted, wider upper address
    eer_top #(.DENSITY(EER_DENS_512)) u_dut_big (
        .sys_clk_i, .rst_n_i, .link_clk_i, .cs_n_i, .strobe_i, .strobe_o(), .hp_event_i,
        .hp_addr_i, .hp_single_i, .hp_check_i, .hp_double_i, .hp_multi_prog_i,
        .overlay_mode_i, .any_overlay_i, .overlay_exit_i, .unit_sel_i, .unit_addr_i,
        .unit_ecc_off_i, .unit_data_err_i, .unit_check_err_i, .count_clear_i,
        .trap_type_select_i, .strobe_stall_control_i, .rd_sel_i, .rd_data_o(rd_data_big),
        .addr_valid_o()
    );
    // ==========================================================
    // tasks
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // bounded wait for chip select, then let the synchroniser settle
    task automatic wait_cs(input logic lvl);
        for (int i = 0; i < 200 && cs_n_i !== lvl; i++) @(posedge sys_clk_i);
        if (cs_n_i !== lvl) begin
            bad_count++;
            end_sim();
        end
        repeat (4) @(posedge sys_clk_i);
    endtask
    // reset spans a short frame so the link domain sees clock edges too
    task automatic hw_reset;
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        frame <= 1'b1;
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        frame <= 1'b0;
        wait_cs(1'b1);
    endtask
    // one decoded half-page, pulse held for a single cycle
    task automatic ev(input logic [ADDR_W-1:0] a, input logic s, input logic d,
                      input logic mp);
        @(posedge sys_clk_i);
        hp_event_i <= 1'b1;
        hp_addr_i <= a;
        {hp_single_i, hp_double_i, hp_multi_prog_i} <= {s, d, mp};
        @(posedge sys_clk_i);
        hp_event_i <= 1'b0;
    endtask
    // command pulse: 0 exit, 1 unit select, 2 counter clear
    task automatic cmd(input int k);
        @(posedge sys_clk_i);
        overlay_exit_i <= (k == 0);
        unit_sel_i <= (k == 1);
        count_clear_i <= (k == 2);
        @(posedge sys_clk_i);
        {overlay_exit_i, unit_sel_i, count_clear_i} <= 3'h0;
    endtask
    task automatic rd(input string nm, input eer_sel_e s, input logic [15:0] m,
                      input logic [15:0] e);
        @(posedge sys_clk_i);
        rd_sel_i <= s;
        repeat (2) @(posedge sys_clk_i);
        #1;
        `CK(nm, e, rd_data_o & m)
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {hp_event_i, hp_single_i, hp_check_i, hp_double_i, hp_multi_prog_i} = 5'h00;
        {overlay_mode_i, any_overlay_i, overlay_exit_i, unit_sel_i} = 4'h0;
        {unit_ecc_off_i, unit_data_err_i, unit_check_err_i, count_clear_i} = 4'h0;
        {trap_type_select_i, strobe_stall_control_i, frame} = 3'h6;
        {hp_addr_i, unit_addr_i} = '0;
        rd_sel_i = EER_SEL_STATUS;
        rst_n_i = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        hw_reset();
        for (int k = 0; k < 4; k++) rd("reset", eer_sel_e'(k), 16'hFFFF, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk_i);
            {unit_check_err_i, unit_data_err_i, unit_ecc_off_i} <= 3'(k);
            unit_addr_i <= ADDR_W'(k * 16);
            cmd(1);
            rd("unit", EER_SEL_STATUS, 16'hFFFF, 16'(k));
        end
        {unit_check_err_i, unit_data_err_i, unit_ecc_off_i} <= 3'h0;
        cmd(0);
        // first trap wins, upper address bit above the density is dropped
        ev(25'h1ABCDEF, 1'b1, 1'b0, 1'b0);
        rd("corr", EER_SEL_STATUS, 16'hFFFF, 16'h0008);
        `CK("valid", 1'b1, addr_valid_o)
        ev(25'h0012340, 1'b1, 1'b0, 1'b0);
        rd("low", EER_SEL_ADDR_L, 16'hFFFF, 16'hCDE8);
        `CK("low_big", 16'h0000, rd_data_big)
        rd("high", EER_SEL_ADDR_H, 16'hFFFF, 16'h00AB);
        unit_ecc_off_i <= 1'b1;
        cmd(1);
        rd("global", EER_SEL_STATUS, 16'hFFFF, 16'h0009);
        cmd(2);
        {overlay_mode_i, any_overlay_i, unit_ecc_off_i} <= 3'b110;
        ev(25'h0000200, 1'b1, 1'b0, 1'b0);
        rd("count", EER_SEL_COUNT, 16'hFFFF, 16'h0002);
        `CK("count_big", 16'h0000, rd_data_big)
        cmd(0);
        {overlay_mode_i, any_overlay_i} <= 2'b00;
        rd("exit", EER_SEL_STATUS, 16'hFFFF, 16'h0000);
        `CK("valid", 1'b0, addr_valid_o)
        rd("low", EER_SEL_ADDR_L, 16'hFFFF, 16'h0000);
        rd("count", EER_SEL_COUNT, 16'hFFFF, 16'h0002);
        {overlay_mode_i, any_overlay_i} <= 2'b11;
        cmd(2);
        rd("count", EER_SEL_COUNT, 16'hFFFF, 16'h0000);
        cmd(0);
        {overlay_mode_i, any_overlay_i, trap_type_select_i} <= 3'b000;
        // double only: single not trapped, bits 3..1 masked after a double
        ev(25'h0000150, 1'b1, 1'b0, 1'b0);
        rd("low", EER_SEL_ADDR_L, 16'hFFFF, 16'h0000);
        ev(25'h1AAAA38, 1'b0, 1'b1, 1'b0);
        rd("dbl", EER_SEL_STATUS, 16'hFFF1, 16'h0010);
        rd("low", EER_SEL_ADDR_L, 16'hFFFF, 16'hAA38);
        rd("high", EER_SEL_ADDR_H, 16'hFFFF, 16'h00AA);
        `CK("high_big", 16'h01AA, rd_data_big)
        cmd(0);
        ev(25'h0000500, 1'b1, 1'b0, 1'b1);
        rd("count", EER_SEL_COUNT, 16'hFFFF, 16'h0002);
        `CK("valid", 1'b0, addr_valid_o)
        // one count per half-page per burst, again in a new burst
        frame <= 1'b1;
        wait_cs(1'b0);
        ev(25'h0000700, 1'b1, 1'b0, 1'b0);
        ev(25'h0000700, 1'b1, 1'b0, 1'b0);
        ev(25'h0000710, 1'b1, 1'b0, 1'b0);
        frame <= 1'b0;
        wait_cs(1'b1);
        frame <= 1'b1;
        wait_cs(1'b0);
        ev(25'h0000700, 1'b1, 1'b0, 1'b0);
        rd("count", EER_SEL_COUNT, 16'hFFFF, 16'h0005);
        // stall on a double holds until chip select rises, counting goes on meanwhile
        strobe_stall_control_i <= 1'b0;
        repeat (10) @(posedge link_clk_i);
        #1;
        `CK("bus_err", 1'b0, bus_err)
        ev(25'h0000800, 1'b0, 1'b1, 1'b0);
        ev(25'h0000900, 1'b1, 1'b0, 1'b0);
        repeat (45) @(posedge link_clk_i);
        #1;
        `CK("strobe", 1'b0, strobe_o)
        `CK("bus_err", 1'b1, bus_err)
        frame <= 1'b0;
        wait_cs(1'b1);
        `CK("strobe_idle", strobe_i, strobe_o)
        strobe_stall_control_i <= 1'b1;
        frame <= 1'b1;
        wait_cs(1'b0);
        ev(25'h0000A00, 1'b0, 1'b1, 1'b0);
        repeat (45) @(posedge link_clk_i);
        #1;
        `CK("no_stall", 1'b0, bus_err)
        frame <= 1'b0;
        wait_cs(1'b1);
        rd("count", EER_SEL_COUNT, 16'hFFFF, 16'h0008);
        // back-to-back distinct half-pages drive the counter to its ceiling
        @(posedge sys_clk_i);
        {hp_event_i, hp_single_i, hp_double_i} <= 3'b110;
        for (int i = 0; i < 65536; i++) begin
            hp_addr_i <= ADDR_W'(32'h0100000 + i * 16);
            @(posedge sys_clk_i);
        end
        hp_event_i <= 1'b0;
        rd("sat", EER_SEL_COUNT, 16'hFFFF, 16'hFFFF);
        ev(25'h0000B00, 1'b1, 1'b0, 1'b0);
        rd("sat", EER_SEL_COUNT, 16'hFFFF, 16'hFFFF);
        hw_reset();
        rd("count", EER_SEL_COUNT, 16'hFFFF, 16'h0000);
        rd("status", EER_SEL_STATUS, 16'hFFFF, 16'h0000);
        end_sim();
    end
endmodule
